// ---- verilog/rbm_pkg.sv ----
// ==========================================================
// reset, boot and mode control constants
package rbm_pkg;

    // ==========================================================
    // register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int PM_ADDR_W = 14;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MODE_STAT = 8'h08;
    localparam logic [7:0] OFS_IMASK = 8'h0C;
    localparam logic [7:0] OFS_STACK = 8'h10;

    // control register fields
    localparam int CTRL_CLKDIS_BIT = 0;
    localparam int CTRL_FLAG_OE_BIT = 1;
    localparam int CTRL_FLAG_OUT_BIT = 2;
    localparam int CTRL_OSC_CLR_BIT = 3;
    localparam int CTRL_KEEP_W = 3;
    localparam logic [2:0] CTRL_RST = 3'h0;

    // status register fields
    localparam int ST_MODE_LSB = 0;
    localparam int ST_STATE_LSB = 4;
    localparam int ST_EXEC_BIT = 7;
    localparam int ST_FLAG_BIT = 8;
    localparam int ST_OSC_BIT = 9;
    localparam int ST_BUSREQ_BIT = 10;
    localparam int ST_EXT_BIT = 11;

    // reset values
    localparam logic [15:0] MODE_STAT_RST = 16'h0000;
    localparam logic [15:0] IMASK_RST = 16'h0000;
    localparam logic [3:0] STACK_EMPTY = 4'h0;
    localparam int STACK_N = 4;
    localparam logic [15:0] DATA_ZERO = 16'h0000;

    // boot figures
    localparam int BOOT_CNT_W = 6;
    localparam logic [5:0] BOOT_WORDS = 6'h20;
    localparam logic [5:0] BOOT_CNT_ONE = 6'h01;
    localparam logic [13:0] FETCH_INT_ADDR = 14'h0000;
    localparam logic [13:0] FETCH_EXT_ADDR = 14'h0000;
    localparam logic [13:0] HOST_BOOT_ADDR = 14'h0000;

    // timing: longest oscillator gap, rounded down, at least one cycle
    localparam int CLK_PERIOD_NS = 20;
    localparam int OSC_GAP_NS = 400;
    localparam int OSC_GAP_CYC = (OSC_GAP_NS / CLK_PERIOD_NS < 1) ? 1 :
                                 OSC_GAP_NS / CLK_PERIOD_NS;
    localparam int OSC_CNT_W = 8;

    // input synchroniser lanes
    localparam int SYNC_W = 6;
    localparam int SY_BUSREQ_N = 0;
    localparam int SY_MODE_A = 1;
    localparam int SY_MODE_B = 2;
    localparam int SY_MODE_D = 3;
    localparam int SY_FLAG = 4;
    localparam int SY_OSC = 5;

    // strap set, order d c b a
    typedef struct packed {
        logic ack_pull_ext;
        logic host_mode;
        logic no_autoboot;
        logic host_src;
    } rbm_mode_t;
    localparam rbm_mode_t MODE_RST = 4'h0;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } rbm_reg_req_t;

    typedef struct packed {
        logic valid;
        logic to_pm;
        logic [13:0] addr;
    } rbm_host_wr_t;

    typedef enum logic [2:0] {
        ST_HOLD = 3'b000,
        ST_BUS_WAIT = 3'b001,
        ST_BYTE_LOAD = 3'b010,
        ST_HOST_LOAD = 3'b011,
        ST_RUN = 3'b100
    } rbm_state_t;

endpackage : rbm_pkg

// ---- verilog/rbm_ctrl.sv ----
// Contract
// - instruction clock twice oscillator input rate
// - cycle clock output gated by disable bit
// - later resets need no stabilization wait
// - reset empties stacks, masks interrupts, clears status
// - boot only if straps allow, no bus request
// - after boot fetch internal address zero
// - sample four straps while reset low
// - host strap: 0 full, 1 host mode
// - auto-boot strap: 0 enabled, 1 disabled
// - source strap: 0 byte dma, 1 host dma; full mode always boots by byte dma
// - byte dma boot waits for 32 words
// - host dma boot waits program address zero
// - no boot, full mode: external address zero
// - ack strap 0 drives, 1 open source
// - host strap pin becomes flag two after reset
`timescale 1ns/1ns
module rbm_ctrl #(
    parameter logic [5:0] BOOT_WORDS_P = rbm_pkg::BOOT_WORDS, // words loaded by byte dma boot
    parameter int OSC_GAP_CYC_P = rbm_pkg::OSC_GAP_CYC        // longest oscillator edge gap
) (
    input wire logic ref_clk,                            // internal clock, two per instruction
    input wire logic reset_n,                            // master reset pin
    input wire logic oscillator_input,                   // oscillator pin, monitored only
    input wire logic bus_request_n,                      // external bus request pin
    input wire logic strap_mode_a,                       // boot source strap pin
    input wire logic strap_mode_b,                       // auto-boot strap pin
    input wire logic strap_mode_d,                       // ack drive strap pin
    input wire logic programmable_flag_two_in,           // flag two pin level, host strap
    output logic programmable_flag_two_out,              // flag two drive level
    output logic programmable_flag_two_oe,               // flag two drive enable
    input wire logic host_ack_ready,                     // host dma ready to acknowledge
    output logic host_access_ack_n_out,                  // ack pin level, low is ack
    output logic host_access_ack_oe,                     // ack pin drive enable
    input wire logic boot_word_stored,                   // pulse: one boot word stored
    input wire rbm_pkg::rbm_host_wr_t host_dma_wr,       // host dma write into memory
    input wire rbm_pkg::rbm_reg_req_t reg_req,           // register port request
    output logic [15:0] reg_rdata,                       // read data, cycle after read
    output logic cycle_clock_output,                     // cycle clock pin
    output rbm_pkg::rbm_mode_t mode_out,                 // latched strap set
    output logic boot_byte_req,                          // byte dma boot load in progress
    output logic exec_enable,                            // core may execute
    output logic [13:0] fetch_addr,                      // first fetch address
    output logic fetch_external                          // first fetch from external memory
);
    import rbm_pkg::*;

    // ==========================================================
    // assertion defaults
    default clocking def_cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // declarations
    localparam logic [7:0] OSC_LIMIT = 8'(OSC_GAP_CYC_P);

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [SYNC_W-1:0] sync3_ff;
    logic [SYNC_W-1:0] filt_ff;
    logic [2:0] rel_ff;
    logic rel_pulse;
    rbm_state_t state_ff;
    rbm_state_t nxt_state;
    rbm_mode_t mode_ff;
    rbm_mode_t nxt_mode;
    logic [5:0] word_cnt_ff;
    logic [2:0] ctrl_ff;
    logic [15:0] mode_stat_ff;
    logic [15:0] imask_ff;
    logic [STACK_N*4-1:0] stack_ff;
    logic [7:0] osc_cnt_ff;
    logic osc_prev_ff;
    logic osc_stall_ff;
    logic osc_edge;
    logic bus_pending;
    logic host_boot_hit;
    logic boot_done;
    logic [15:0] status_word;

    // address decode shared by the write and read paths
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // ==========================================================
    // input synchronisers
    // no reset here: straps must keep flowing while reset is low
    always_ff @(posedge ref_clk) begin
        sync1_ff <= {oscillator_input, programmable_flag_two_in, strap_mode_d,
                     strap_mode_b, strap_mode_a, bus_request_n};
        sync2_ff <= sync1_ff;
        sync3_ff <= sync2_ff;
    end

    // a lane changes once the second and third stage agree
    generate
        for (genvar gi = 0; gi < SYNC_W; gi++) begin : g_filt
            always_ff @(posedge ref_clk) begin
                if (sync2_ff[gi] == sync3_ff[gi]) begin
                    filt_ff[gi] <= sync3_ff[gi];
                end
            end
        end
    endgenerate

    assign bus_pending = !filt_ff[SY_BUSREQ_N];

    // ==========================================================
    // reset release detection
    // the clock keeps running through any later reset, so the
    // release is seen two edges later, with no stabilization count
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rel_ff <= 3'h0;
        end else begin
            rel_ff <= {rel_ff[1:0], 1'b1};
        end
    end

    assign rel_pulse = rel_ff[1] & ~rel_ff[2];

    // ==========================================================
    // strap latch
    // straps sampled during reset, captured as reset releases
    always_comb begin
        nxt_mode = mode_ff;
        if (rel_pulse) begin
            nxt_mode.host_mode = filt_ff[SY_FLAG];
            nxt_mode.no_autoboot = filt_ff[SY_MODE_B];
            nxt_mode.host_src = filt_ff[SY_MODE_A];
            nxt_mode.ack_pull_ext = filt_ff[SY_MODE_D];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= MODE_RST;
        end else begin
            mode_ff <= nxt_mode;
        end
    end

    assign mode_out = mode_ff;

    mode_hold_a: assert property ((state_ff != ST_HOLD) |=> $stable(mode_ff))
        else $error("strap set changed outside reset release");

    // ==========================================================
    // boot sequencer
    // full memory mode has no host dma port, so it always boots by byte dma
    assign host_boot_hit = host_dma_wr.valid && host_dma_wr.to_pm &&
                           (host_dma_wr.addr == HOST_BOOT_ADDR);
    assign boot_done = boot_word_stored && (word_cnt_ff == BOOT_WORDS_P - BOOT_CNT_ONE);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_HOLD: begin
                if (rel_pulse) begin
                    if (nxt_mode.no_autoboot) begin
                        nxt_state = ST_RUN;
                    end else if (bus_pending) begin
                        nxt_state = ST_BUS_WAIT;
                    end else if (nxt_mode.host_mode && nxt_mode.host_src) begin
                        nxt_state = ST_HOST_LOAD;
                    end else begin
                        nxt_state = ST_BYTE_LOAD;
                    end
                end
            end
            ST_BUS_WAIT: begin
                if (!bus_pending) begin
                    nxt_state = (mode_ff.host_mode && mode_ff.host_src) ?
                                ST_HOST_LOAD : ST_BYTE_LOAD;
                end
            end
            ST_BYTE_LOAD: begin
                if (boot_done) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_HOST_LOAD: begin
                if (host_boot_hit) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                nxt_state = ST_RUN;
            end
            default: begin
                nxt_state = ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // boot word counter, only byte dma completions in the boot state count
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_cnt_ff <= '0;
        end else if (state_ff == ST_BYTE_LOAD && boot_word_stored) begin
            word_cnt_ff <= word_cnt_ff + BOOT_CNT_ONE;
        end
    end

    // execution start and first fetch address
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            exec_enable <= 1'b0;
            fetch_addr <= FETCH_INT_ADDR;
            fetch_external <= 1'b0;
            boot_byte_req <= 1'b0;
        end else begin
            exec_enable <= (nxt_state == ST_RUN);
            boot_byte_req <= (nxt_state == ST_BYTE_LOAD);
            if (state_ff == ST_HOLD && nxt_state == ST_RUN && !nxt_mode.host_mode) begin
                fetch_addr <= FETCH_EXT_ADDR;
                fetch_external <= 1'b1;
            end else if (state_ff != ST_RUN && nxt_state == ST_RUN) begin
                fetch_addr <= FETCH_INT_ADDR;
                fetch_external <= 1'b0;
            end
        end
    end

    sequence boot_wanted_s;
        (state_ff == ST_HOLD) && rel_pulse && !nxt_mode.no_autoboot;
    endsequence

    boot_start_a: assert property (boot_wanted_s and !bus_pending |=>
                                   (state_ff == ST_BYTE_LOAD || state_ff == ST_HOST_LOAD))
        else $error("boot did not start at reset release");
    bus_defer_a: assert property (boot_wanted_s and bus_pending |=>
                                  (state_ff == ST_BUS_WAIT) && !exec_enable)
        else $error("boot ran with a bus request pending");
    release_go_a: assert property (rel_pulse |=> (state_ff != ST_HOLD))
        else $error("sequencer waited after reset release");
    fetch_zero_a: assert property ($rose(exec_enable) && !fetch_external |->
                                   (fetch_addr == FETCH_INT_ADDR))
        else $error("first internal fetch not at address zero");
    byte_count_a: assert property ($rose(exec_enable) && boot_byte_req == 1'b0 &&
                                   $past(state_ff) == ST_BYTE_LOAD |->
                                   (word_cnt_ff == BOOT_WORDS_P))
        else $error("execution began before all boot words were stored");
    host_wait_a: assert property ((state_ff == ST_HOST_LOAD) && !host_boot_hit |=>
                                  !exec_enable)
        else $error("execution began before program address zero was written");
    ext_start_a: assert property ((state_ff == ST_HOLD) && rel_pulse && nxt_mode.no_autoboot &&
                                  !nxt_mode.host_mode |=> exec_enable && fetch_external &&
                                  (fetch_addr == FETCH_EXT_ADDR))
        else $error("no-boot start not at external address zero");

    // ==========================================================
    // instruction clock and cycle clock output
    // one ref_clk edge per half instruction cycle; the oscillator
    // runs at half the instruction rate, so it toggles every two cycles
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cycle_clock_output <= 1'b0;
        end else if (ctrl_ff[CTRL_CLKDIS_BIT]) begin
            cycle_clock_output <= 1'b0;
        end else begin
            cycle_clock_output <= ~cycle_clock_output;
        end
    end

    clk_gate_a: assert property (ctrl_ff[CTRL_CLKDIS_BIT] |=> !cycle_clock_output)
        else $error("cycle clock ran while disabled");
    clk_run_a: assert property (!ctrl_ff[CTRL_CLKDIS_BIT] |=>
                                (cycle_clock_output != $past(cycle_clock_output)))
        else $error("cycle clock missed a phase");

    // ==========================================================
    // oscillator watch
    // a stopped oscillator is only legal in power-down, which this block
    // does not model, so any long gap is flagged sticky; set wins over clear
    assign osc_edge = (filt_ff[SY_OSC] != osc_prev_ff);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            osc_prev_ff <= 1'b0;
            osc_cnt_ff <= '0;
            osc_stall_ff <= 1'b0;
        end else begin
            osc_prev_ff <= filt_ff[SY_OSC];
            if (osc_edge) begin
                osc_cnt_ff <= '0;
            end else if (osc_cnt_ff != OSC_LIMIT) begin
                osc_cnt_ff <= osc_cnt_ff + 8'h01;
            end
            if (!osc_edge && osc_cnt_ff == OSC_LIMIT) begin
                osc_stall_ff <= 1'b1;
            end else if (reg_req.wr && hit(reg_req.addr, OFS_CTRL) &&
                         reg_req.wdata[CTRL_OSC_CLR_BIT]) begin
                osc_stall_ff <= 1'b0;
            end
        end
    end

    // ==========================================================
    // flag two and host acknowledge pins
    // flag two stays undriven through reset so a strap driver can set it
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            programmable_flag_two_oe <= 1'b0;
            programmable_flag_two_out <= 1'b0;
        end else begin
            programmable_flag_two_oe <= ctrl_ff[CTRL_FLAG_OE_BIT] && (state_ff != ST_HOLD);
            programmable_flag_two_out <= ctrl_ff[CTRL_FLAG_OUT_BIT];
        end
    end

    // open source: only the high level is driven, a pull-down makes ack
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            host_access_ack_n_out <= 1'b1;
            host_access_ack_oe <= 1'b0;
        end else begin
            host_access_ack_n_out <= ~host_ack_ready;
            if (!mode_ff.host_mode || state_ff == ST_HOLD) begin
                host_access_ack_oe <= 1'b0;
            end else if (!mode_ff.ack_pull_ext) begin
                host_access_ack_oe <= 1'b1;
            end else begin
                host_access_ack_oe <= ~host_ack_ready;
            end
        end
    end

    flag_free_a: assert property ((state_ff == ST_HOLD) |=> !programmable_flag_two_oe)
        else $error("flag two driven during reset");
    ack_drive_a: assert property (mode_ff.host_mode && !mode_ff.ack_pull_ext &&
                                  (state_ff != ST_HOLD) |=> host_access_ack_oe)
        else $error("ack pin not driven with drive strap low");
    ack_open_a: assert property (mode_ff.host_mode && mode_ff.ack_pull_ext && host_ack_ready &&
                                 (state_ff != ST_HOLD) |=> !host_access_ack_oe)
        else $error("ack pin driven low in open source setting");

    // ==========================================================
    // software registers
    // master reset empties the stacks, masks all interrupts and clears status
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= CTRL_RST;
            mode_stat_ff <= MODE_STAT_RST;
            imask_ff <= IMASK_RST;
            stack_ff <= {STACK_N{STACK_EMPTY}};
        end else if (reg_req.wr) begin
            if (hit(reg_req.addr, OFS_CTRL)) begin
                ctrl_ff <= reg_req.wdata[CTRL_KEEP_W-1:0];
            end
            if (hit(reg_req.addr, OFS_MODE_STAT)) begin
                mode_stat_ff <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_IMASK)) begin
                imask_ff <= reg_req.wdata;
            end
            if (hit(reg_req.addr, OFS_STACK)) begin
                stack_ff <= reg_req.wdata;
            end
        end
    end

    reset_clear_a: assert property (rel_pulse |-> (mode_stat_ff == MODE_STAT_RST) &&
                                    (imask_ff == IMASK_RST) &&
                                    (stack_ff == {STACK_N{STACK_EMPTY}}))
        else $error("state not cleared by master reset");

    // status word shows the block's own state
    always_comb begin
        status_word = DATA_ZERO;
        status_word[ST_MODE_LSB +: 4] = mode_ff;
        status_word[ST_STATE_LSB +: 3] = state_ff;
        status_word[ST_EXEC_BIT] = exec_enable;
        status_word[ST_FLAG_BIT] = filt_ff[SY_FLAG];
        status_word[ST_OSC_BIT] = osc_stall_ff;
        status_word[ST_BUSREQ_BIT] = bus_pending;
        status_word[ST_EXT_BIT] = fetch_external;
    end

    // read data valid only in the cycle after the read strobe
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= DATA_ZERO;
        end else if (!reg_req.rd) begin
            reg_rdata <= DATA_ZERO;
        end else if (hit(reg_req.addr, OFS_CTRL)) begin
            reg_rdata <= {13'h0000, ctrl_ff};
        end else if (hit(reg_req.addr, OFS_STATUS)) begin
            reg_rdata <= status_word;
        end else if (hit(reg_req.addr, OFS_MODE_STAT)) begin
            reg_rdata <= mode_stat_ff;
        end else if (hit(reg_req.addr, OFS_IMASK)) begin
            reg_rdata <= imask_ff;
        end else if (hit(reg_req.addr, OFS_STACK)) begin
            reg_rdata <= stack_ff;
        end else begin
            reg_rdata <= DATA_ZERO;
        end
    end

endmodule : rbm_ctrl

// ---- testbench/rbm_board.sv ----
`timescale 1ns/1ns
// ==========================================================
// board model: reset circuit, strap drivers, oscillator
module rbm_board (
    input wire logic ref_clk,        // system clock
    input wire logic rst_hold,       // bench asks for reset
    input wire logic [3:0] strap,    // strap levels, order d c b a
    input wire logic busreq,         // bench raises a bus request
    input wire logic pf_out,         // device flag two level
    input wire logic pf_oe,          // device flag two enable
    output logic reset_n,            // reset pin
    output logic oscillator_input,   // oscillator pin
    output logic strap_mode_a,       // boot source strap
    output logic strap_mode_b,       // auto-boot strap
    output logic strap_mode_d,       // ack drive strap
    output logic pf_pin,             // flag two pin level
    output logic bus_request_n       // bus request pin, pulled up when idle
);
    logic [13:0] pwr_cnt_ff = 14'h0000;
    logic [1:0] osc_cnt_ff = 2'h0;
    // oscillator never stops: one period is four system clocks
    always @(posedge ref_clk) osc_cnt_ff <= osc_cnt_ff + 2'h1;
    // power-up: no release before 2000 oscillator periods have passed
    always @(posedge ref_clk) if (pwr_cnt_ff != 14'h1F40) pwr_cnt_ff <= pwr_cnt_ff + 14'h0001;
    assign oscillator_input = osc_cnt_ff[1];
    assign reset_n = ~rst_hold & (pwr_cnt_ff == 14'h1F40);
    assign {strap_mode_d, strap_mode_b, strap_mode_a} = {strap[3], strap[1], strap[0]};
    // strap driver only while reset is low; a weak resistor holds the same level later
    assign pf_pin = (!reset_n || !pf_oe) ? strap[2] : pf_out;
    assign bus_request_n = ~busreq;
endmodule : rbm_board

// ---- testbench/tb.sv ----
`timescale 1ns/1ns
// ==========================================================
// bench for reset, boot and mode control
module tb;
    import rbm_pkg::*;
    localparam logic [5:0] NW = 6'h04;
    logic ref_clk, rst_hold, busreq, host_ack_ready, boot_word_stored, reset_n, osc, sa, sb, sd;
    logic pf_in, pf_out, pf_oe, ack_n, ack_oe, busreq_n, cclk, byte_req, exec, fext, c1;
    logic [3:0] strap;
    logic [15:0] reg_rdata, q;
    logic [13:0] faddr;
    rbm_mode_t mode;
    rbm_host_wr_t hwr;
    rbm_reg_req_t rq;
    int miscompares, tests_run;
    rbm_board board (.ref_clk(ref_clk), .rst_hold(rst_hold), .strap(strap), .busreq(busreq),
        .pf_out(pf_out), .pf_oe(pf_oe), .reset_n(reset_n), .oscillator_input(osc),
        .strap_mode_a(sa), .strap_mode_b(sb), .strap_mode_d(sd), .pf_pin(pf_in),
        .bus_request_n(busreq_n));
    rbm_ctrl #(.BOOT_WORDS_P(NW), .OSC_GAP_CYC_P(OSC_GAP_CYC)) DUT (.ref_clk(ref_clk),
        .reset_n(reset_n), .oscillator_input(osc), .bus_request_n(busreq_n), .strap_mode_a(sa),
        .strap_mode_b(sb), .strap_mode_d(sd), .programmable_flag_two_in(pf_in),
        .programmable_flag_two_out(pf_out), .programmable_flag_two_oe(pf_oe),
        .host_ack_ready(host_ack_ready), .host_access_ack_n_out(ack_n),
        .host_access_ack_oe(ack_oe), .boot_word_stored(boot_word_stored), .host_dma_wr(hwr),
        .reg_req(rq), .reg_rdata(reg_rdata), .cycle_clock_output(cclk), .mode_out(mode),
        .boot_byte_req(byte_req), .exec_enable(exec), .fetch_addr(faddr), .fetch_external(fext));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_of_test;
        if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // one register access; read data sampled in the cycle after the strobe
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        rq <= '{w, ~w, a, d};
        @(posedge ref_clk);
        rq <= '{1'b0, 1'b0, a, d};
        #1 q = reg_rdata;
    endtask : acc
    // straps held well around the release edge, first access at the fifth edge
    task automatic do_reset(input logic [3:0] s);
        @(posedge ref_clk);
        strap <= s;
        rst_hold <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_hold <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
    endtask : do_reset
    task automatic pulse(input logic [15:0] n);
        repeat (n) begin
            @(posedge ref_clk);
            boot_word_stored <= 1'b1;
            @(posedge ref_clk);
            boot_word_stored <= 1'b0;
        end
        @(posedge ref_clk);
        #1;
    endtask : pulse
    task automatic host_wr(input logic pm, input logic [13:0] a);
        @(posedge ref_clk);
        hwr <= '{1'b1, pm, a};
        @(posedge ref_clk);
        hwr <= '0;
        @(posedge ref_clk);
        #1;
    endtask : host_wr
    // ==========================================================
    // main sequence
    initial begin
        {rst_hold, busreq, host_ack_ready, boot_word_stored, strap} = 8'h82;
        hwr = '0;
        rq = '0;
        miscompares = 0;
        tests_run = 0;
        repeat (8010) @(posedge ref_clk);
        do_reset(4'h2);
        check("mode", mode, 16'h0002);
        check("start", {exec, fext, faddr}, 16'hC000);
        for (int i = 0; i < 3; i++) begin
            acc(1'b1, 8'(8 + 4 * i), 16'hFFFF);
            acc(1'b0, 8'(8 + 4 * i), 16'h0000);
            check("store", q, 16'hFFFF);
        end
        strap <= 4'hD;
        c1 = cclk;
        @(posedge ref_clk);
        #1 check("cclk", cclk, !c1);
        acc(1'b1, OFS_CTRL, 16'h0003);
        repeat (4) @(posedge ref_clk);
        acc(1'b0, OFS_STATUS, 16'h0000);
        check("cclk off", {cclk, pf_oe, q[9:8]}, 16'h0004);
        check("latched", mode, 16'h0002);
        acc(1'b1, OFS_CTRL, 16'h0000);
        do_reset(4'h0);
        for (int i = 0; i < 3; i++) begin
            acc(1'b0, 8'(8 + 4 * i), 16'hFFFF);
            check("cleared", q, 16'h0000);
        end
        check("byte boot", {byte_req, exec}, 16'h0002);
        pulse(16'(NW) - 16'h0001);
        check("held", exec, 16'h0000);
        pulse(16'h0001);
        check("booted", {byte_req, exec, fext}, 16'h0002);
        check("boot addr", faddr, 16'h0000);
        busreq <= 1'b1;
        do_reset(4'h0);
        repeat (4) @(posedge ref_clk);
        #1 check("bus wait", {byte_req, exec}, 16'h0000);
        busreq <= 1'b0;
        for (int i = 0; i < 20 && byte_req !== 1'b1; i++) @(posedge ref_clk);
        #1 check("bus free", byte_req, 16'h0001);
        do_reset(4'h5);
        check("host", {mode, ack_oe}, 16'h000B);
        host_wr(1'b0, 14'h0000);
        host_wr(1'b1, 14'h0001);
        check("host held", exec, 16'h0000);
        host_wr(1'b1, 14'h0000);
        check("host run", {exec, fext, faddr}, 16'h8000);
        host_ack_ready <= 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 check("ack level", ack_n, 16'h0000);
        do_reset(4'hD);
        check("ack open", {mode, ack_oe}, 16'h001A);
        host_ack_ready <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 check("ack drive", ack_oe, 16'h0001);
        end_of_test();
    end
endmodule : tb
